// ---- bcs_fifo.v ----
`timescale 1ns/1ps
`default_nettype none
module bcs_fifo #(
    parameter W  = 8,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire         clk,
    input  wire         reset_n,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0]  mem_r [0:D-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0]   count_r;
    wire         do_wr;
    wire         do_rd;

    assign in_ready  = (count_r != D[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem_r[rd_r];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    always @(posedge clk)
    begin
        if (do_wr)
            mem_r[wr_r] <= in_data;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_r    <= {AW{1'b0}};
            rd_r    <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wr_r <= (wr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
            if (do_rd)
                rd_r <= (rd_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
            if (do_wr && !do_rd)
                count_r <= count_r + 1'b1;
            else if (do_rd && !do_wr)
                count_r <= count_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- bcs_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcs_host (
    input wire logic core_clk,
    input wire logic txd,
    output var logic rxd
);
    initial rxd = 1'b1;

    // 8n1 frame, lsb first, line idles high
    task automatic send_byte(input logic [7:0] b, input int cyc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge core_clk);
            rxd = f[i];
            repeat (cyc - 1) @(negedge core_clk);
        end
    endtask

    task automatic low_pulse(input int n);
        @(negedge core_clk);
        rxd = 1'b0;
        repeat (n) @(negedge core_clk);
        rxd = 1'b1;
    endtask

    // returns unknown data and ok low when no frame comes within tmo cycles
    task automatic recv_byte(output logic [7:0] b, output logic ok, input int cyc, input int tmo);
        int n;
        b  = 8'hxx;
        ok = 1'b0;
        n  = 0;
        while (txd !== 1'b0 && n < tmo)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= tmo)
            return;
        repeat (cyc / 2) @(negedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (cyc) @(negedge core_clk);
            b[i] = txd;
        end
        repeat (cyc) @(negedge core_clk);
        ok = (txd === 1'b1);
    endtask
endmodule
`default_nettype wire

// ---- bcs_regs.vh ----
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// core clock and the opening link rate
`define BCS_CLK_HZ          50000000
`define BCS_BASE_BPS        9600
`define BCS_BASE_BIT_CYC    (`BCS_CLK_HZ / `BCS_BASE_BPS)
// matching byte: start bit plus bit 0 give a low pulse of two bit times
`define BCS_MATCH_LOW_MIN   16'd9115
`define BCS_MATCH_LOW_MAX   16'd11718

// protocol byte values, error repeat count and last error index
`define BCS_MATCH_BYTE      8'h5A
`define BCS_CMD_SUM         8'h90
`define BCS_ERR_HEAD0       8'hA1
`define BCS_ERR_HEAD1       8'hA3
`define BCS_ERR_BAUD        8'h62
`define BCS_ERR_CMD         8'h63
`define BCS_ERR_REPEAT      3
`define BCS_ERR_LAST_IDX    4'd8

// baud rate modification codes and the bit times they select
`define BCS_BAUD_CODE0      8'h28
`define BCS_BAUD_CODE1      8'h18
`define BCS_BAUD_CODE2      8'h10
`define BCS_BAUD_CODE3      8'h08
`define BCS_BAUD_CYC0       16'd5208
`define BCS_BAUD_CYC1       16'd2604
`define BCS_BAUD_CYC2       16'd1302
`define BCS_BAUD_CYC3       16'd651

// transmit buffer
`define BCS_FIFO_DEPTH      4
`define BCS_FIFO_AW         2

// bytes summed by the checksum
`define BCS_FLASH_BYTES     61440

`endif

// ---- bcs_top.v ----
// Notes on behaviour
// - The host opens with the matching byte 5AH at 9600 bps and the device learns the bit time from it.
// - An accepted matching byte is echoed as 5AH; a failed match gets no reply at all.
// - The third byte picks the new rate and is echoed, or A1H, A3H and 62H each go out three times.
// - From the fifth byte on, both directions run at the modified rate.
// - A fifth byte of 90H is echoed back as the sixth byte.
// - Any other fifth byte sends the error sequence ending in 63H three times and then halts.
// - After the echo the checksum goes out upper byte first, then lower byte.
// - After both checksum bytes the device waits for a new command at the same rate.
// - The first four bytes are handled as for the flash writing exchange.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"
module bcs_top #(
    parameter FLASH_BYTES = `BCS_FLASH_BYTES,
    parameter AW          = 16
) (
    input  wire          core_clk,
    input  wire          reset_n,
    input  wire          rxd,
    output wire          txd,
    output reg  [AW-1:0] flash_addr,
    input  wire [7:0]    flash_rd_data,
    output reg           halted
);
    localparam [3:0] S_MIDLE  = 4'd0;
    localparam [3:0] S_MLOW   = 4'd1;
    localparam [3:0] S_MTAIL  = 4'd2;
    localparam [3:0] S_BAUD   = 4'd3;
    localparam [3:0] S_BDRAIN = 4'd4;
    localparam [3:0] S_CMD    = 4'd5;
    localparam [3:0] S_CALC   = 4'd6;
    localparam [3:0] S_SUMHI  = 4'd7;
    localparam [3:0] S_SUMLO  = 4'd8;
    localparam [3:0] S_ERR    = 4'd9;
    localparam [3:0] S_HALT   = 4'd10;
    localparam [AW-1:0] LAST_ADDR = FLASH_BYTES[AW-1:0] - 1'b1;

    reg [3:0]    state_r;
    reg [15:0]   cnt_r;
    reg [15:0]   bit_cyc_r;
    reg [15:0]   new_cyc_r;
    reg          push_r;
    reg [7:0]    push_data_r;
    reg [3:0]    err_idx_r;
    reg [7:0]    err_last_r;
    reg [15:0]   sum_r;
    reg          issuing_r;
    reg          rd_valid_r;
    wire         rx_en;
    wire [7:0]   rx_data;
    wire         rx_valid;
    wire         fifo_ready;
    wire         fifo_out_valid;
    wire [7:0]   fifo_out_data;
    wire         tx_ready;
    wire         tx_busy;
    wire [16:0]  tail_cyc;
    wire [15:0]  baud_lookup;
    wire [7:0]   err_code;

    function [15:0] baud_cyc;
        input [7:0] code;
        begin
            case (code)
                `BCS_BAUD_CODE0: baud_cyc = `BCS_BAUD_CYC0;
                `BCS_BAUD_CODE1: baud_cyc = `BCS_BAUD_CYC1;
                `BCS_BAUD_CODE2: baud_cyc = `BCS_BAUD_CYC2;
                `BCS_BAUD_CODE3: baud_cyc = `BCS_BAUD_CYC3;
                default:         baud_cyc = 16'h0000;
            endcase
        end
    endfunction

    assign rx_en       = (state_r == S_BAUD) || (state_r == S_CMD);
    assign baud_lookup = baud_cyc(rx_data);
    // rest of the matching byte after its first rising edge: eight bits plus half
    assign tail_cyc    = {bit_cyc_r[13:0], 3'b000} + {2'b00, bit_cyc_r[15:1]};
    assign err_code    = (err_idx_r < `BCS_ERR_REPEAT) ? `BCS_ERR_HEAD0 :
                         (err_idx_r < 2 * `BCS_ERR_REPEAT) ? `BCS_ERR_HEAD1 : err_last_r;

    bcs_uart u_uart (
        .clk      (core_clk),
        .reset_n  (reset_n),
        .bit_cyc  (bit_cyc_r),
        .rx_en    (rx_en),
        .rxd      (rxd),
        .rx_data  (rx_data),
        .rx_valid (rx_valid),
        .tx_valid (fifo_out_valid),
        .tx_ready (tx_ready),
        .tx_data  (fifo_out_data),
        .txd      (txd),
        .tx_busy  (tx_busy)
    );

    // replies queue here; a stalled line holds the state machine back
    bcs_fifo #(
        .W  (8),
        .D  (`BCS_FIFO_DEPTH),
        .AW (`BCS_FIFO_AW)
    ) u_fifo (
        .clk       (core_clk),
        .reset_n   (reset_n),
        .in_valid  (push_r),
        .in_ready  (fifo_ready),
        .in_data   (push_data_r),
        .out_valid (fifo_out_valid),
        .out_ready (tx_ready),
        .out_data  (fifo_out_data)
    );

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r     <= S_MIDLE;
            cnt_r       <= 16'h0000;
            bit_cyc_r   <= `BCS_BAUD_CYC0;
            new_cyc_r   <= `BCS_BAUD_CYC0;
            push_r      <= 1'b0;
            push_data_r <= 8'h00;
            err_idx_r   <= 4'h0;
            err_last_r  <= 8'h00;
            sum_r       <= 16'h0000;
            issuing_r   <= 1'b0;
            rd_valid_r  <= 1'b0;
            flash_addr  <= {AW{1'b0}};
            halted      <= 1'b0;
        end
        else
        begin
            if (push_r && fifo_ready)
                push_r <= 1'b0;
            case (state_r)
                S_MIDLE:
                begin
                    if (!rxd)
                    begin
                        cnt_r   <= 16'h0001;
                        state_r <= S_MLOW;
                    end
                end
                S_MLOW:
                begin
                    if (rxd)
                    begin
                        cnt_r <= 16'h0000;
                        // out-of-range pulse: silently wait for another try
                        if (cnt_r >= `BCS_MATCH_LOW_MIN && cnt_r <= `BCS_MATCH_LOW_MAX)
                        begin
                            bit_cyc_r <= {1'b0, cnt_r[15:1]};
                            state_r   <= S_MTAIL;
                        end
                        else
                            state_r <= S_MIDLE;
                    end
                    else if (cnt_r != 16'hFFFF)
                        cnt_r <= cnt_r + 16'h0001;
                end
                S_MTAIL:
                begin
                    cnt_r <= cnt_r + 16'h0001;
                    if ({1'b0, cnt_r} >= tail_cyc)
                    begin
                        push_r      <= 1'b1;
                        push_data_r <= `BCS_MATCH_BYTE;
                        state_r     <= S_BAUD;
                    end
                end
                S_BAUD:
                begin
                    if (rx_valid)
                    begin
                        if (baud_lookup != 16'h0000)
                        begin
                            new_cyc_r   <= baud_lookup;
                            push_r      <= 1'b1;
                            push_data_r <= rx_data;
                            state_r     <= S_BDRAIN;
                        end
                        else
                        begin
                            err_last_r <= `BCS_ERR_BAUD;
                            err_idx_r  <= 4'h0;
                            state_r    <= S_ERR;
                        end
                    end
                end
                S_BDRAIN:
                begin
                    // echo goes out at 9600 before the rate changes
                    if (!push_r && !fifo_out_valid && !tx_busy)
                    begin
                        bit_cyc_r <= new_cyc_r;
                        state_r   <= S_CMD;
                    end
                end
                S_CMD:
                begin
                    if (rx_valid)
                    begin
                        if (rx_data == `BCS_CMD_SUM)
                        begin
                            push_r      <= 1'b1;
                            push_data_r <= rx_data;
                            sum_r       <= 16'h0000;
                            flash_addr  <= {AW{1'b0}};
                            issuing_r   <= 1'b1;
                            state_r     <= S_CALC;
                        end
                        else
                        begin
                            err_last_r <= `BCS_ERR_CMD;
                            err_idx_r  <= 4'h0;
                            state_r    <= S_ERR;
                        end
                    end
                end
                S_CALC:
                begin
                    rd_valid_r <= issuing_r;
                    if (rd_valid_r)
                        sum_r <= sum_r + {8'h00, flash_rd_data};
                    if (issuing_r)
                    begin
                        if (flash_addr == LAST_ADDR)
                            issuing_r <= 1'b0;
                        else
                            flash_addr <= flash_addr + 1'b1;
                    end
                    else if (!rd_valid_r)
                        state_r <= S_SUMHI;
                end
                S_SUMHI:
                begin
                    if (!push_r)
                    begin
                        push_r      <= 1'b1;
                        push_data_r <= sum_r[15:8];
                        state_r     <= S_SUMLO;
                    end
                end
                S_SUMLO:
                begin
                    if (!push_r)
                    begin
                        push_r      <= 1'b1;
                        push_data_r <= sum_r[7:0];
                        state_r     <= S_CMD;
                    end
                end
                S_ERR:
                begin
                    if (!push_r)
                    begin
                        push_r      <= 1'b1;
                        push_data_r <= err_code;
                        err_idx_r   <= err_idx_r + 4'h1;
                        if (err_idx_r == `BCS_ERR_LAST_IDX)
                            state_r <= S_HALT;
                    end
                end
                S_HALT:
                begin
                    // halt shows only once the last error code has left txd
                    if (!push_r && !fifo_out_valid && !tx_busy)
                        halted <= 1'b1;
                end
                default:
                begin
                    state_r <= S_MIDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- bcs_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"
module bcs_top_monitor #(
    parameter FLASH_BYTES = 16,
    parameter AW          = 16
) (
    input wire logic          core_clk,
    input wire logic          reset_n,
    input wire logic          rxd,
    input wire logic          txd,
    input wire logic [AW-1:0] flash_addr,
    input wire logic [7:0]    flash_rd_data,
    input wire logic          halted
);
    logic        rx_seen_r;
    logic        txd_q_r;
    logic        rxd_q_r;
    logic [7:0]  fall_cnt_r;
    logic [15:0] low_cnt_r;
    logic [13:0] halt_cnt_r;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_seen_r  <= 1'b0;
            txd_q_r    <= 1'b1;
            rxd_q_r    <= 1'b1;
            fall_cnt_r <= 8'h00;
            low_cnt_r  <= 16'h0000;
            halt_cnt_r <= 14'h0000;
        end
        else
        begin
            rx_seen_r <= rx_seen_r | ~rxd;
            txd_q_r   <= txd;
            rxd_q_r   <= rxd;
            // txd falls counted since the host last drove a falling edge
            if (rxd_q_r && !rxd)
                fall_cnt_r <= 8'h00;
            else if (txd_q_r && !txd && fall_cnt_r != 8'hFF)
                fall_cnt_r <= fall_cnt_r + 8'h01;
            if (txd)
                low_cnt_r <= 16'h0000;
            else if (low_cnt_r != 16'hFFFF)
                low_cnt_r <= low_cnt_r + 16'h0001;
            if (!halted)
                halt_cnt_r <= 14'h0000;
            else if (halt_cnt_r != 14'h1FFF)
                halt_cnt_r <= halt_cnt_r + 14'h0001;
        end
    end

    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    property p_reset_idle;
        !$past(reset_n) |-> txd && flash_addr == '0 && !halted;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
    property p_quiet_before_rx;
        !rx_seen_r |-> txd;
    endproperty
    a_quiet_before_rx: assert property (p_quiet_before_rx) else $error("txd active unprompted");
    property p_start_hold;
        $fell(txd) |=> (!txd) [*8];
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start bit too short");
    property p_low_run;
        $rose(txd) |-> low_cnt_r >= `BCS_BAUD_CYC3;
    endproperty
    a_low_run: assert property (p_low_run) else $error("txd low run below bit time");
    property p_addr_step;
        flash_addr != $past(flash_addr) |-> flash_addr == $past(flash_addr) + 1'b1 || flash_addr == '0;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("flash address skipped");
    property p_addr_range;
        flash_addr < FLASH_BYTES;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("flash address out of range");
    property p_halt_sticky;
        halted |=> halted;
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt state left");
    property p_halt_quiet;
        halt_cnt_r == 14'h1FFF |-> txd;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("txd active while halted");
    property p_halt_after_codes;
        // each of the nine error codes holds three falling edges
        $rose(halted) |-> fall_cnt_r == 8'h1B;
    endproperty
    a_halt_after_codes: assert property (p_halt_after_codes) else $error("halt before codes");
    property p_halt_addr;
        halted |-> $stable(flash_addr);
    endproperty
    a_halt_addr: assert property (p_halt_addr) else $error("flash address moves in halt");
endmodule

bind bcs_top bcs_top_monitor #(
    .FLASH_BYTES(FLASH_BYTES),
    .AW         (AW)
) u_mon (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .rxd          (rxd),
    .txd          (txd),
    .flash_addr   (flash_addr),
    .flash_rd_data(flash_rd_data),
    .halted       (halted)
);
`default_nettype wire

// ---- bcs_uart.v ----
`timescale 1ns/1ps
`default_nettype none
module bcs_uart (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [15:0] bit_cyc,
    input  wire        rx_en,
    input  wire        rxd,
    output reg  [7:0]  rx_data,
    output reg         rx_valid,
    input  wire        tx_valid,
    output wire        tx_ready,
    input  wire [7:0]  tx_data,
    output reg         txd,
    output wire        tx_busy
);
    reg        rx_run_r;
    reg [15:0] rx_cnt_r;
    reg [3:0]  rx_bit_r;
    reg [7:0]  rx_sh_r;
    reg        tx_run_r;
    reg [15:0] tx_cnt_r;
    reg [3:0]  tx_bit_r;
    reg [8:0]  tx_sh_r;

    assign tx_ready = !tx_run_r;
    assign tx_busy  = tx_run_r;

    // receiver: samples each bit at its middle
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_run_r <= 1'b0;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r  <= 8'h00;
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (!rx_en)
                rx_run_r <= 1'b0;
            else if (!rx_run_r)
            begin
                if (!rxd)
                begin
                    rx_run_r <= 1'b1;
                    rx_cnt_r <= {1'b0, bit_cyc[15:1]};
                    rx_bit_r <= 4'h0;
                end
            end
            else if (rx_cnt_r != 16'h0000)
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            else
            begin
                rx_cnt_r <= bit_cyc - 16'h0001;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0)
                begin
                    if (rxd)
                        rx_run_r <= 1'b0;
                end
                else if (rx_bit_r == 4'h9)
                begin
                    rx_run_r <= 1'b0;
                    if (rxd)
                    begin
                        rx_data  <= rx_sh_r;
                        rx_valid <= 1'b1;
                    end
                end
                else
                    rx_sh_r <= {rxd, rx_sh_r[7:1]};
            end
        end
    end

    // transmitter: start, eight data bits lsb first, stop
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_run_r <= 1'b0;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 4'h0;
            tx_sh_r  <= 9'h1FF;
            txd      <= 1'b1;
        end
        else if (!tx_run_r)
        begin
            if (tx_valid)
            begin
                tx_run_r <= 1'b1;
                txd      <= 1'b0;
                tx_sh_r  <= {1'b1, tx_data};
                tx_cnt_r <= bit_cyc - 16'h0001;
                tx_bit_r <= 4'h0;
            end
        end
        else if (tx_cnt_r != 16'h0000)
            tx_cnt_r <= tx_cnt_r - 16'h0001;
        else if (tx_bit_r == 4'h9)
            tx_run_r <= 1'b0;
        else
        begin
            txd      <= tx_sh_r[0];
            tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
            tx_cnt_r <= bit_cyc - 16'h0001;
            tx_bit_r <= tx_bit_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ---- test_bcs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"
module test_bcs_top;
    localparam int FLASH_N = 16;
    localparam int SLOW    = `BCS_BAUD_CYC0;
    localparam int FAST    = `BCS_BAUD_CYC3;

    logic        core_clk;
    logic        reset_n;
    wire         rxd;
    wire         txd;
    wire  [15:0] flash_addr;
    logic [7:0]  flash_rd_data;
    logic [15:0] addr_q;
    wire         halted;
    int          errors;
    int          num_checks;
    logic [15:0] sum_exp;

    bcs_top #(
        .FLASH_BYTES(FLASH_N),
        .AW         (16)
    ) uut (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .rxd          (rxd),
        .txd          (txd),
        .flash_addr   (flash_addr),
        .flash_rd_data(flash_rd_data),
        .halted       (halted)
    );

    bcs_host host (
        .core_clk(core_clk),
        .txd     (txd),
        .rxd     (rxd)
    );

    function automatic logic [7:0] fbyte(input logic [15:0] a);
        return a[7:0] * 8'h07 + 8'h03;
    endfunction

    // one-cycle read latency: data at an edge belongs to the address of the cycle before
    always @(negedge core_clk)
    begin
        addr_q        <= flash_addr;
        flash_rd_data <= fbyte(addr_q);
    end

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic xfer(input logic [7:0] tx, input int cyc, output logic [7:0] got);
        logic ok;
        fork
            host.send_byte(tx, cyc);
            host.recv_byte(got, ok, cyc, 120000);
        join
    endtask

    task automatic t_bad_match;
        logic [7:0] b;
        logic       ok;
        host.low_pulse(3000);
        host.recv_byte(b, ok, SLOW, 30000);
        check({7'h00, ok}, 8'h00);
    endtask

    task automatic t_open;
        logic [7:0] b;
        xfer(`BCS_MATCH_BYTE, SLOW, b);
        check(b, `BCS_MATCH_BYTE);
        xfer(`BCS_BAUD_CODE3, SLOW, b);
        check(b, `BCS_BAUD_CODE3);
        // the new rate applies only after the echo's stop bit has fully left
        repeat (SLOW) @(negedge core_clk);
    endtask

    task automatic t_sum;
        logic [7:0] b;
        logic       ok;
        xfer(`BCS_CMD_SUM, FAST, b);
        check(b, `BCS_CMD_SUM);
        host.recv_byte(b, ok, FAST, 20000);
        check(b, sum_exp[15:8]);
        host.recv_byte(b, ok, FAST, 20000);
        check(b, sum_exp[7:0]);
    endtask

    task automatic t_bad_cmd;
        logic [7:0] exp [9];
        logic [7:0] b;
        logic       ok;
        exp = '{8'hA1, 8'hA1, 8'hA1, 8'hA3, 8'hA3, 8'hA3, 8'h63, 8'h63, 8'h63};
        xfer(8'h33, FAST, b);
        check(b, exp[0]);
        for (int i = 1; i < 9; i++)
        begin
            host.recv_byte(b, ok, FAST, 20000);
            check(b, exp[i]);
        end
        repeat (4 * FAST) @(negedge core_clk);
        check({7'h00, halted}, 8'h01);
        fork
            host.send_byte(`BCS_CMD_SUM, FAST);
            host.recv_byte(b, ok, FAST, 20000);
        join
        check({7'h00, ok}, 8'h00);
    endtask

    initial
    begin
        reset_n    = 1'b0;
        errors     = 0;
        num_checks = 0;
        sum_exp    = 16'h0000;
        for (int a = 0; a < FLASH_N; a++)
            sum_exp = sum_exp + {8'h00, fbyte(a[15:0])};
        repeat (16) @(negedge core_clk);
        reset_n = 1'b1;
        t_bad_match();
        t_open();
        t_sum();
        t_sum();
        t_bad_cmd();
        report_and_stop();
    end

    // about 400k cycles of traffic, mostly the two opening bytes at the slow rate
    initial
    begin
        #12000000;
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
